// >>> rtd_top.sv
// Purpose: Receive status capture, error tallies and transmit DMA setup for a 10 Mbit/s MAC.
// Assumes: Receiver event strobes come from logic on hclk; carrier, collision and jabber
//          come from pins and are synchronised here.
// Notes:   Registers are reached over AHB-Lite with zero wait states.
//
// How it works
// R01: Good packet status byte stored with packet.
// R02: Saved errored packet gets status at head.
// R03: Rejected errored packets store no status byte.
// R04: Status packet bits clear when packet begins.
// R05: Count CRC, alignment, missed packets internally.
// R06: Host ignores status before first reception.
// R07: Intact only when error and missed bits clear.
// R08: CRC bit set also on alignment; tally counts.
// R09: Misaligned with bad CRC sets alignment bit.
// R10: FIFO overflow sets bit and aborts packet.
// R11: Unaccepted addressed packet sets missed, counts.
// R12: Bit five: physical zero, multicast one.
// R13: Receiver-off bit follows monitor mode.
// R14: Deferring bit on carrier, collision, held jabber.
// R15: Alignment/CRC pair never reads one-zero.
// R16: All registers are eight bits wide.
// R17: Page registers give upper address byte only.
// R18: Transmit start loads page, low byte zero.
// R19: Host counts addresses, length and data bytes.
// R20: Byte count is at most 64 Kbytes.
// R21: Full byte count sent, never truncated.
// R22: Packet outcome bits update together at end.
`timescale 1ns/1ps
`include "rtd_params.svh"
module rtd_top import rtd_pkg::*; #(
	parameter int TALLY_W = 8, // Width of each tally counter.
	parameter int LEN_W = 16 // Width of the transmit byte counter.
) (
	input wire logic hclk, // System clock, 250 MHz.
	input wire logic hresetn, // Asynchronous reset, active low.
	input wire logic clk_en, // Clock enable; all state holds while low.
	input wire logic hsel, // AHB slave select.
	input wire logic [31:0] haddr, // AHB address.
	input wire logic [1:0] htrans, // AHB transfer type.
	input wire logic hwrite, // AHB write flag.
	input wire logic [2:0] hsize, // AHB transfer size.
	input wire logic [31:0] hwdata, // AHB write data.
	input wire logic hready, // AHB bus ready.
	output logic hreadyout, // AHB slave ready.
	output logic hresp, // AHB response, always OKAY.
	output logic [31:0] hrdata, // AHB read data.
	input wire logic rx_begin, // Pulse: a packet begins to arrive.
	input wire logic rx_done, // Pulse: packet reception has ended.
	input wire logic rx_crc_bad, // Level at rx_done: CRC mismatch.
	input wire logic rx_odd_bits, // Level at rx_done: not ended on a byte boundary.
	input wire logic rx_addr_hit, // Level at rx_done: address recognised.
	input wire logic rx_group_addr, // Level at rx_done: multicast or broadcast match.
	input wire logic rx_no_buffer, // Level at rx_done: no receive buffer free.
	input wire logic rx_fifo_full, // Pulse: receive FIFO overflowed.
	input wire logic carrier_pin, // Pin: internal carrier sense.
	input wire logic collision_pin, // Pin: collision.
	input wire logic jabber_pin, // Pin: transceiver collision due to jabber.
	output logic rx_abort_q, // Pulse: abort current reception.
	output logic stat_store_q, // Pulse: store status byte to buffer memory.
	output logic stat_at_head_q, // With stat_store_q: place at packet head.
	output logic [7:0] stat_byte_q, // Status byte to store.
	output logic [15:0] tx_dma_addr_q, // Local DMA address for transmit.
	output logic tx_active_q, // Transmission in progress.
	input wire logic tx_byte_take, // Pulse: one byte fetched for transmit.
	output logic tx_last_q // Pulse: final byte fetched.
);

	// ------------
	// Declarations
	// ------------
	logic [2:0] pins_s; // Synchronised carrier, collision and jabber.
	logic ap_wr_q, ap_wr_d; // Data phase of a write is pending.
	logic [7:0] ap_addr_q, ap_addr_d; // Captured write address.
	logic [31:0] rdata_q, rdata_d; // Registered read data.
	logic [7:0] tx_page_q, tx_page_d; // Transmit page start.
	logic [7:0] tx_len_lo_q, tx_len_lo_d; // Transmit byte count, low byte.
	logic [7:0] tx_len_hi_q, tx_len_hi_d; // Transmit byte count, high byte.
	logic [1:0] cfg_q, cfg_d; // Save-errors and monitor mode bits.
	logic tx_go; // Software start pulse, from a write.
	logic addr_ph; // A valid address phase is taken.
	logic rd_align, rd_crc, rd_miss; // Tally registers being read.
	logic [7:0] ap_a; // Low address bits of the address phase.
	rtd_rx_state_type rx_st_q, rx_st_d; // Receive tracking state.
	logic [`RTD_PKT_BITS-1:0] pkt_q, pkt_d; // Packet outcome status bits.
	logic ovf_q, ovf_d; // Overflow seen in current packet.
	logic abort_d, store_d, head_d; // Next values of pulse outputs.
	logic [7:0] sbyte_d; // Next stored status byte.
	logic [TALLY_W-1:0] t_align_q, t_align_d; // Alignment error tally.
	logic [TALLY_W-1:0] t_crc_q, t_crc_d; // CRC error tally.
	logic [TALLY_W-1:0] t_miss_q, t_miss_d; // Missed packet tally.
	logic inc_align, inc_crc, inc_miss; // Tally increments.
	logic defer_q, defer_d; // Deferring bit.
	rtd_tx_state_type tx_st_q, tx_st_d; // Transmit state.
	logic [15:0] tx_addr_d; // Next local DMA address.
	logic [LEN_W-1:0] tx_left_q, tx_left_d; // Bytes still to fetch.
	logic last_d; // Next final-byte pulse.
	logic [7:0] status_view; // Live status register value.

	// ------------
	// Functions
	// ------------
	// Tally step: clear on read, saturating increment; an increment in the cycle of a clear counts from zero.
	function automatic logic [TALLY_W-1:0] tally_step(input logic [TALLY_W-1:0] cur,
			input logic inc, input logic clr);
		logic [TALLY_W-1:0] nxt;
		nxt = clr ? TALLY_W'(0) : cur;
		if (inc && nxt != TALLY_W'(`RTD_TALLY_MAX)) begin
			nxt = nxt + TALLY_W'(1);
		end
		return nxt;
	endfunction

	// Widen an 8-bit register to a bus word with zeros above.
	function automatic logic [31:0] word_of(input logic [7:0] b);
		return {24'h000000, b};
	endfunction

	// ------------
	// Pin synchroniser
	// ------------
	// Carrier, collision and jabber arrive from the transceiver side.
	rtd_sync #(
		.W(3)
	) u_pins (
		.hclk(hclk),
		.hresetn(hresetn),
		.clk_en(clk_en),
		.pin_in({jabber_pin, collision_pin, carrier_pin}),
		.sync_q(pins_s)
	);

	// ------------
	// AHB-Lite slave
	// ------------
	// The slave never stalls except while the clock enable holds state.
	assign hreadyout = clk_en;
	assign hresp = 1'b0;
	assign hrdata = rdata_q;
	assign ap_a = haddr[7:0];
	assign addr_ph = hsel && hready && (htrans == `RTD_HTRANS_NONSEQ ||
		htrans == `RTD_HTRANS_SEQ) && (haddr[31:8] == 24'h000000);
	assign rd_align = addr_ph && !hwrite && ap_a == `RTD_A_ALIGN_TALLY;
	assign rd_crc = addr_ph && !hwrite && ap_a == `RTD_A_CRC_TALLY;
	assign rd_miss = addr_ph && !hwrite && ap_a == `RTD_A_MISS_TALLY;
	assign tx_go = ap_wr_q && ap_addr_q == `RTD_A_TX_CTRL && hwdata[`RTD_B_TX_GO];
	assign status_view = {defer_q, cfg_q[`RTD_B_MONITOR], pkt_q}; // [R13] [R14]

	// Decode the address phase for reads, and apply writes in the data phase.
	always_comb begin
		ap_wr_d = addr_ph && hwrite;
		ap_addr_d = ap_a;
		rdata_d = `RTD_WORD_ZERO;
		tx_page_d = tx_page_q;
		tx_len_lo_d = tx_len_lo_q;
		tx_len_hi_d = tx_len_hi_q;
		cfg_d = cfg_q;
		if (addr_ph && !hwrite) begin
			if (ap_a == `RTD_A_RX_STATUS) begin
				rdata_d = word_of(status_view); // [R16]
			end else if (ap_a == `RTD_A_TX_PAGE) begin
				rdata_d = word_of(tx_page_q);
			end else if (ap_a == `RTD_A_TX_LEN_LO) begin
				rdata_d = word_of(tx_len_lo_q);
			end else if (ap_a == `RTD_A_TX_LEN_HI) begin
				rdata_d = word_of(tx_len_hi_q);
			end else if (ap_a == `RTD_A_RX_CFG) begin
				rdata_d = word_of({6'h00, cfg_q});
			end else if (ap_a == `RTD_A_ALIGN_TALLY) begin
				rdata_d = word_of(t_align_q);
			end else if (ap_a == `RTD_A_CRC_TALLY) begin
				rdata_d = word_of(t_crc_q);
			end else if (ap_a == `RTD_A_MISS_TALLY) begin
				rdata_d = word_of(t_miss_q);
			end else if (ap_a == `RTD_A_TX_CTRL) begin
				rdata_d = word_of({6'h00, tx_st_q == RTD_TX_RUN, 1'b0});
			end else begin
				rdata_d = `RTD_WORD_ZERO; // Unmapped reads return zero.
			end
		end
		if (ap_wr_q) begin
			// Each register takes only the low byte of the write data.
			if (ap_addr_q == `RTD_A_TX_PAGE) begin
				tx_page_d = hwdata[7:0]; // [R17]
			end else if (ap_addr_q == `RTD_A_TX_LEN_LO) begin
				tx_len_lo_d = hwdata[7:0]; // [R16]
			end else if (ap_addr_q == `RTD_A_TX_LEN_HI) begin
				tx_len_hi_d = hwdata[7:0]; // [R16]
			end else if (ap_addr_q == `RTD_A_RX_CFG) begin
				cfg_d = hwdata[1:0];
			end
		end
	end

	// Register bus state.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_wr_q <= 1'b0;
			ap_addr_q <= `RTD_BYTE_ZERO;
			rdata_q <= `RTD_WORD_ZERO;
			tx_page_q <= `RTD_BYTE_ZERO;
			tx_len_lo_q <= `RTD_BYTE_ZERO;
			tx_len_hi_q <= `RTD_BYTE_ZERO;
			cfg_q <= 2'h0;
		end else if (clk_en) begin
			ap_wr_q <= ap_wr_d;
			ap_addr_q <= ap_addr_d;
			rdata_q <= rdata_d;
			tx_page_q <= tx_page_d;
			tx_len_lo_q <= tx_len_lo_d;
			tx_len_hi_q <= tx_len_hi_d;
			cfg_q <= cfg_d;
		end
	end

	// ------------
	// Receive status capture
	// ------------
	// Track one packet, then commit its outcome and decide where the status goes.
	always_comb begin
		logic crc_e, align_e, miss_e, err_e;
		crc_e = 1'b0;
		align_e = 1'b0;
		miss_e = 1'b0;
		err_e = 1'b0;
		rx_st_d = rx_st_q;
		pkt_d = pkt_q;
		ovf_d = ovf_q;
		abort_d = 1'b0;
		store_d = 1'b0;
		head_d = 1'b0;
		sbyte_d = stat_byte_q;
		inc_align = 1'b0;
		inc_crc = 1'b0;
		inc_miss = 1'b0;
		case (rx_st_q)
			RTD_RX_IDLE: begin
				if (rx_begin) begin
					pkt_d = '0; // [R04]
					ovf_d = 1'b0;
					rx_st_d = RTD_RX_BUSY;
				end
			end
			RTD_RX_BUSY: begin
				if (rx_fifo_full && !ovf_q) begin
					ovf_d = 1'b1; // [R10]
					abort_d = 1'b1; // [R10]
				end
				if (rx_done) begin
					crc_e = rx_crc_bad; // [R08]
					align_e = rx_crc_bad && rx_odd_bits; // [R09] [R15]
					miss_e = rx_addr_hit && (rx_no_buffer || cfg_q[`RTD_B_MONITOR]); // [R11]
					err_e = crc_e || ovf_d;
					pkt_d[`RTD_B_CRC] = crc_e; // [R22]
					pkt_d[`RTD_B_ALIGN] = align_e;
					pkt_d[`RTD_B_OVERFLOW] = ovf_d;
					pkt_d[`RTD_B_MISSED] = miss_e;
					pkt_d[`RTD_B_MCAST] = rx_group_addr; // [R12]
					pkt_d[`RTD_B_INTACT] = !(crc_e || align_e || ovf_d || miss_e); // [R07]
					inc_crc = rx_addr_hit && crc_e; // [R05] [R08]
					inc_align = rx_addr_hit && align_e; // [R05] [R09]
					inc_miss = miss_e; // [R05] [R11]
					sbyte_d = {defer_q, cfg_q[`RTD_B_MONITOR], pkt_d};
					if (rx_addr_hit && !miss_e) begin
						if (!err_e) begin
							store_d = 1'b1; // [R01]
						end else if (cfg_q[`RTD_B_SAVE_ERR]) begin
							store_d = 1'b1; // [R02]
							head_d = 1'b1; // [R02]
						end else begin
							store_d = 1'b0; // [R03]
						end
					end
					rx_st_d = RTD_RX_IDLE;
				end
			end
			default: begin
				rx_st_d = RTD_RX_IDLE;
			end
		endcase
		// Receiver-off tracks monitor mode; deferring holds while jabber is signalled.
		defer_d = pins_s[0] || pins_s[1] || pins_s[2]; // [R14]
		t_align_d = tally_step(t_align_q, inc_align, rd_align);
		t_crc_d = tally_step(t_crc_q, inc_crc, rd_crc);
		t_miss_d = tally_step(t_miss_q, inc_miss, rd_miss);
	end

	// Register receive state, status and tallies. [R13]
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_st_q <= RTD_RX_IDLE;
			pkt_q <= '0;
			ovf_q <= 1'b0;
			rx_abort_q <= 1'b0;
			stat_store_q <= 1'b0;
			stat_at_head_q <= 1'b0;
			stat_byte_q <= `RTD_BYTE_ZERO;
			t_align_q <= '0;
			t_crc_q <= '0;
			t_miss_q <= '0;
			defer_q <= 1'b0;
		end else if (clk_en) begin
			rx_st_q <= rx_st_d;
			pkt_q <= pkt_d;
			ovf_q <= ovf_d;
			rx_abort_q <= abort_d;
			stat_store_q <= store_d;
			stat_at_head_q <= head_d;
			stat_byte_q <= sbyte_d;
			t_align_q <= t_align_d;
			t_crc_q <= t_crc_d;
			t_miss_q <= t_miss_d;
			defer_q <= defer_d;
		end
	end

	// ------------
	// Transmit local DMA
	// ------------
	// Load the page start and count on start, then walk the full count.
	always_comb begin
		tx_st_d = tx_st_q;
		tx_addr_d = tx_dma_addr_q;
		tx_left_d = tx_left_q;
		last_d = 1'b0;
		case (tx_st_q)
			RTD_TX_IDLE: begin
				if (tx_go) begin
					tx_addr_d = {tx_page_q, `RTD_BYTE_ZERO}; // [R18]
					tx_left_d = LEN_W'({tx_len_hi_q, tx_len_lo_q}); // [R20]
					if ({tx_len_hi_q, tx_len_lo_q} != 16'h0000) begin
						tx_st_d = RTD_TX_RUN;
					end
				end
			end
			RTD_TX_RUN: begin
				if (tx_byte_take) begin
					tx_addr_d = tx_dma_addr_q + 16'h0001;
					tx_left_d = tx_left_q - LEN_W'(1); // [R21]
					if (tx_left_q == LEN_W'(1)) begin
						last_d = 1'b1; // [R21]
						tx_st_d = RTD_TX_IDLE;
					end
				end
			end
			default: begin
				tx_st_d = RTD_TX_IDLE;
			end
		endcase
	end

	// Register transmit state.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_st_q <= RTD_TX_IDLE;
			tx_dma_addr_q <= 16'h0000;
			tx_left_q <= '0;
			tx_last_q <= 1'b0;
			tx_active_q <= 1'b0;
		end else if (clk_en) begin
			tx_st_q <= tx_st_d;
			tx_dma_addr_q <= tx_addr_d;
			tx_left_q <= tx_left_d;
			tx_last_q <= last_d;
			tx_active_q <= (tx_st_d == RTD_TX_RUN);
		end
	end

endmodule // rtd_top

// >>> rtd_params.svh
// Purpose: Register map, field positions and fixed counts of the receive status and
//          transmit DMA setup block.
// Assumes: Included once by every file that needs a constant.
// Notes:   Register offsets are byte addresses on a 32-bit AHB-Lite bus.
`ifndef RTD_PARAMS_SVH
`define RTD_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define RTD_ADDR_W 8
`define RTD_A_RX_STATUS 8'h0C
`define RTD_A_TX_PAGE 8'h10
`define RTD_A_TX_LEN_LO 8'h14
`define RTD_A_TX_LEN_HI 8'h18
`define RTD_A_RX_CFG 8'h1C
`define RTD_A_ALIGN_TALLY 8'h20
`define RTD_A_CRC_TALLY 8'h24
`define RTD_A_MISS_TALLY 8'h28
`define RTD_A_TX_CTRL 8'h2C

// ----------------------------------------------------------------------------
// Receive status field positions
// ----------------------------------------------------------------------------
`define RTD_B_INTACT 0
`define RTD_B_CRC 1
`define RTD_B_ALIGN 2
`define RTD_B_OVERFLOW 3
`define RTD_B_MISSED 4
`define RTD_B_MCAST 5
`define RTD_B_RX_OFF 6
`define RTD_B_DEFER 7
`define RTD_PKT_BITS 6

// ----------------------------------------------------------------------------
// Configuration fields, reset values and counts
// ----------------------------------------------------------------------------
`define RTD_B_SAVE_ERR 0
`define RTD_B_MONITOR 1
`define RTD_B_TX_GO 0
`define RTD_B_TX_BUSY 1
`define RTD_TALLY_MAX 8'hC0
`define RTD_BYTE_ZERO 8'h00
`define RTD_WORD_ZERO 32'h0000_0000
`define RTD_HTRANS_NONSEQ 2'h2
`define RTD_HTRANS_SEQ 2'h3

`endif

// >>> rtd_pkg.sv
// Purpose: Types shared by the receive status and transmit DMA setup block.
// Assumes: Constants live in rtd_params.svh.
// Notes:   State codes are written out in binary.
package rtd_pkg;

	// Receive packet tracking state.
	typedef enum logic [0:0] {
		RTD_RX_IDLE = 1'b0, // Waiting for a packet to begin.
		RTD_RX_BUSY = 1'b1 // A packet is arriving.
	} rtd_rx_state_type;

	// Transmit local DMA state.
	typedef enum logic [0:0] {
		RTD_TX_IDLE = 1'b0, // No transmission in progress.
		RTD_TX_RUN = 1'b1 // Bytes are being fetched for the wire.
	} rtd_tx_state_type;

endpackage

// >>> rtd_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for pin inputs.
// Assumes: Inputs are asynchronous to hclk.
// Notes:   The output changes only once the second and third stages agree.
`timescale 1ns/1ps
module rtd_sync #(
	parameter int W = 1
) (
	input wire logic hclk, // System clock.
	input wire logic hresetn, // Asynchronous reset, active low.
	input wire logic clk_en, // Clock enable; state holds while low.
	input wire logic [W-1:0] pin_in, // Raw pin levels.
	output logic [W-1:0] sync_q // Filtered, synchronised levels.
);

	logic [W-1:0] s1_q, s2_q, s3_q; // Synchroniser stages.
	logic [W-1:0] s1_d, s2_d, s3_d, sync_d; // Next values.

	// ------------------------------------------------------------------------
	// Next values
	// ------------------------------------------------------------------------
	// Shift the stages; update each output bit only where stages two and three agree.
	always_comb begin
		s1_d = pin_in;
		s2_d = s1_q;
		s3_d = s2_q;
		sync_d = sync_q;
		for (int i = 0; i < W; i++) begin
			if (s2_q[i] == s3_q[i]) begin
				sync_d[i] = s3_q[i];
			end
		end
	end

	// Register all stages.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			sync_q <= '0;
		end else if (clk_en) begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			s3_q <= s3_d;
			sync_q <= sync_d;
		end
	end

endmodule // rtd_sync

// >>> rtd_assertions.sv
// Purpose: Concurrent checks on the receive status and transmit DMA ports.
// Assumes: Bound into rtd_top; clk_en is held high by the bench.
// Notes:   A small busy tracker mirrors the packet handshake.
`timescale 1ns/1ps
module rtd_assertions (
	input wire logic hclk, // System clock.
	input wire logic hresetn, // Reset, active low.
	input wire logic rx_begin, // Packet starts.
	input wire logic rx_done, // Packet ends.
	input wire logic rx_crc_bad, // CRC mismatch level.
	input wire logic rx_odd_bits, // Odd bit count level.
	input wire logic rx_addr_hit, // Address recognised.
	input wire logic rx_group_addr, // Group address match.
	input wire logic rx_no_buffer, // No receive buffer.
	input wire logic rx_fifo_full, // FIFO overflow pulse.
	input wire logic rx_abort_q, // Abort pulse.
	input wire logic stat_store_q, // Store pulse.
	input wire logic stat_at_head_q, // Store at packet head.
	input wire logic [7:0] stat_byte_q, // Status byte.
	input wire logic [15:0] tx_dma_addr_q, // Transmit DMA address.
	input wire logic tx_active_q, // Transmit running.
	input wire logic tx_byte_take, // Byte fetched.
	input wire logic tx_last_q // Final byte pulse.
);
	// ------------
	// Packet tracking
	// ------------
	logic busy_q; // A packet is arriving.
	logic busy_d; // Next value of busy_q.
	logic done_ok; // An end of packet that the block accepts.

	assign done_ok = rx_done && busy_q;

	// Idle waits for a start; busy waits for the end.
	always_comb begin
		busy_d = busy_q ? !rx_done : rx_begin;
	end

	// Registers the tracker.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			busy_q <= 1'b0;
		end else begin
			busy_q <= busy_d;
		end
	end

	// ------------
	// Properties
	// ------------
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	AST_CRC_BIT: assert property (done_ok |=> stat_byte_q[1] == $past(rx_crc_bad))
		else $error("CRC status bit wrong.");
	AST_ALIGN_BIT: assert property (done_ok |=> stat_byte_q[2] == $past(rx_crc_bad && rx_odd_bits))
		else $error("Alignment status bit wrong.");
	AST_PAIR_LEGAL: assert property (stat_byte_q[2] |-> stat_byte_q[1])
		else $error("Alignment without CRC error.");
	AST_ADDR_TYPE: assert property (done_ok |=> stat_byte_q[5] == $past(rx_group_addr))
		else $error("Address type bit wrong.");
	AST_MISSED: assert property (done_ok && rx_addr_hit && rx_no_buffer |=> stat_byte_q[4] && !stat_store_q)
		else $error("Missed packet not flagged or stored.");
	AST_INTACT: assert property (stat_store_q |-> stat_byte_q[0] == !(|stat_byte_q[4:1]))
		else $error("Intact bit disagrees with error bits.");
	AST_STORE_CAUSE: assert property (stat_store_q |-> $past(done_ok && rx_addr_hit))
		else $error("Status stored without an accepted packet.");
	AST_HEAD_ERR: assert property (stat_store_q && stat_at_head_q |-> stat_byte_q[1] || stat_byte_q[3])
		else $error("Head placement for a good packet.");
	AST_ABORT_CAUSE: assert property (rx_abort_q |-> $past(rx_fifo_full && busy_q) ##1 !rx_abort_q)
		else $error("Abort pulse without overflow.");
	AST_TX_PAGE: assert property ($rose(tx_active_q) |-> tx_dma_addr_q[7:0] == 8'h00)
		else $error("Transmit start address low byte not zero.");
	AST_TX_END: assert property ($fell(tx_active_q) |-> tx_last_q && $past(tx_byte_take))
		else $error("Transmit ended without final byte.");

	COV_HEAD: cover property (stat_store_q && stat_at_head_q);
	COV_ABORT: cover property (rx_abort_q);
	COV_TX_LAST: cover property (tx_last_q);
endmodule // rtd_assertions

bind rtd_top rtd_assertions u_chk (.hclk(hclk), .hresetn(hresetn), .rx_begin(rx_begin),
	.rx_done(rx_done), .rx_crc_bad(rx_crc_bad), .rx_odd_bits(rx_odd_bits),
	.rx_addr_hit(rx_addr_hit), .rx_group_addr(rx_group_addr), .rx_no_buffer(rx_no_buffer),
	.rx_fifo_full(rx_fifo_full), .rx_abort_q(rx_abort_q), .stat_store_q(stat_store_q),
	.stat_at_head_q(stat_at_head_q), .stat_byte_q(stat_byte_q), .tx_dma_addr_q(tx_dma_addr_q),
	.tx_active_q(tx_active_q), .tx_byte_take(tx_byte_take), .tx_last_q(tx_last_q));

// >>> rtd_fetch_model.sv
// Purpose: Buffer memory side that fetches transmit bytes from the local DMA.
// Assumes: Fetches only while the transmit DMA runs.
// Notes:   Slow mode fetches every other cycle; a stray fetch after the end is ignored.
`timescale 1ns/1ps
module rtd_fetch_model (
	input wire logic hclk, // System clock.
	input wire logic hresetn, // Reset, active low.
	input wire logic slow, // High: fetch every other cycle.
	input wire logic tx_active_q, // Transmit DMA running.
	output logic tx_byte_take, // Pulse: one byte fetched.
	output logic [16:0] n_taken // Bytes fetched while running, up to 64 Kbytes.
);
	logic phase_q; // Alternates to pace slow fetching.

	// Fetches while running and counts the fetches the DMA accepts.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_q <= 1'b0;
			tx_byte_take <= 1'b0;
			n_taken <= 17'h00000;
		end else begin
			phase_q <= !phase_q;
			tx_byte_take <= tx_active_q && (!slow || phase_q);
			if (tx_byte_take && tx_active_q) begin
				n_taken <= n_taken + 17'h00001;
			end
		end
	end
endmodule // rtd_fetch_model

// >>> testbench.sv
// Purpose: Self-checking bench for the receive status and transmit DMA block.
// Assumes: Zero wait state register bus; clk_en held high.
// Notes:   Expected values are worked out from the packet flags given.
`timescale 1ns/1ps
`include "rtd_params.svh"
module testbench;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, slow;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic rx_begin, rx_done, rx_crc_bad, rx_odd_bits, rx_addr_hit, rx_group_addr, rx_no_buffer;
	logic rx_fifo_full, carrier_pin, collision_pin, jabber_pin, tx_byte_take, tx_last_q;
	logic rx_abort_q, stat_store_q, stat_at_head_q, tx_active_q;
	logic [7:0] stat_byte_q, t_crc, t_aln, t_mis; // Status byte and expected tallies.
	logic [15:0] tx_dma_addr_q;
	logic [16:0] n_taken;
	int failures, n_tests;
	logic [5:0] cs [8] = '{6'h01, 6'h09, 6'h21, 6'h31, 6'h11, 6'h03, 6'h05, 6'h20}; // Packet cases.

	assign hready = hreadyout;
	always #2 hclk = ~hclk;

	rtd_top dut (.clk_en(1'b1), .*);
	rtd_fetch_model u_fetch (.*);

	// ------------
	// Shared tasks
	// ------------
	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Waits, bounded, for the slave to be ready at a rising edge.
	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 100);
		if (n >= 100) begin
			failures++;
			finish_test();
		end
	endtask

	// One single word transfer; read data lands in rd.
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= `RTD_HTRANS_NONSEQ;
		hwrite <= wr;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
	endtask

	// Reads after one idle cycle so an earlier write has landed.
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge hclk);
		bus(1'b0, a, 32'h0000_0000);
		chk(rd, exp);
		chk(hresp, 1'b0);
	endtask

	// Sends one packet and judges the status outputs.
	task automatic pkt(input logic crc, odd, grp, nob, ovf, hit, sav, mon);
		logic err, mis, st;
		logic [7:0] eb;
		err = crc | ovf;
		mis = hit & (nob | mon);
		st = hit & !mis & (!err | sav);
		eb = {1'b0, mon, grp, mis, ovf, crc & odd, crc, !(crc | ovf | mis)};
		t_crc += {7'h00, hit & crc};
		t_aln += {7'h00, hit & crc & odd};
		t_mis += {7'h00, mis};
		rx_begin <= 1'b1;
		@(posedge hclk);
		rx_begin <= 1'b0;
		rx_fifo_full <= ovf;
		@(posedge hclk);
		rx_fifo_full <= 1'b0;
		{rx_done, rx_crc_bad, rx_odd_bits, rx_group_addr, rx_no_buffer, rx_addr_hit} <=
			{1'b1, crc, odd, grp, nob, hit};
		@(posedge hclk);
		chk(rx_abort_q, ovf);
		rx_done <= 1'b0;
		@(posedge hclk);
		chk(stat_byte_q, eb);
		chk(stat_store_q, st);
		chk(stat_at_head_q, st & err);
		rdchk(`RTD_A_RX_STATUS, {24'h000000, eb});
	endtask

	// Polls the deferring bit, bounded.
	task automatic poll(input logic e);
		for (int n = 0; n < 20; n++) begin
			bus(1'b0, `RTD_A_RX_STATUS, 32'h0000_0000);
			if (rd[7] === e) break;
		end
		chk(rd[7], e);
	endtask

	// ------------
	// Scenarios
	// ------------
	task automatic t_regs();
		rdchk(`RTD_A_TX_PAGE, 32'h0000_0000);
		bus(1'b1, `RTD_A_TX_LEN_LO, 32'hFFFF_FFA5);
		bus(1'b1, `RTD_A_TX_LEN_HI, 32'h1234_565A);
		bus(1'b1, `RTD_A_RX_STATUS, 32'h0000_00FF);
		bus(1'b1, 8'h40, 32'h0000_00FF);
		rdchk(`RTD_A_TX_LEN_LO, 32'h0000_00A5);
		rdchk(`RTD_A_TX_LEN_HI, 32'h0000_005A);
		rdchk(`RTD_A_RX_STATUS, 32'h0000_0000);
		rdchk(8'h40, 32'h0000_0000);
	endtask

	// Every packet case, first with errored packets rejected, then saved.
	task automatic t_rx();
		for (int s = 0; s < 2; s++) begin
			bus(1'b1, `RTD_A_RX_CFG, s);
			foreach (cs[i]) begin
				pkt(cs[i][5], cs[i][4], cs[i][3], cs[i][2], cs[i][1], cs[i][0], s[0], 1'b0);
			end
		end
	endtask

	task automatic t_mon();
		bus(1'b1, `RTD_A_RX_CFG, 32'h0000_0002);
		pkt(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
		bus(1'b1, `RTD_A_RX_CFG, 32'h0000_0000);
		rdchk(`RTD_A_RX_STATUS, 32'h0000_0010);
	endtask

	// A new packet start clears the packet bits, then tallies are read.
	task automatic t_clear();
		pkt(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
		rx_begin <= 1'b1;
		@(posedge hclk);
		rx_begin <= 1'b0;
		rdchk(`RTD_A_RX_STATUS, 32'h0000_0000);
		rx_done <= 1'b1;
		rx_addr_hit <= 1'b0;
		@(posedge hclk);
		rx_done <= 1'b0;
		rdchk(`RTD_A_ALIGN_TALLY, {24'h000000, t_aln});
		rdchk(`RTD_A_CRC_TALLY, {24'h000000, t_crc});
		rdchk(`RTD_A_MISS_TALLY, {24'h000000, t_mis});
		rdchk(`RTD_A_CRC_TALLY, 32'h0000_0000);
	endtask

	task automatic t_defer();
		for (int i = 0; i < 3; i++) begin
			{jabber_pin, collision_pin, carrier_pin} <= 3'h1 << i;
			poll(1'b1);
			{jabber_pin, collision_pin, carrier_pin} <= 3'h0;
			poll(1'b0);
		end
	endtask

	// A 1502 byte transmit with a slow fetching memory.
	task automatic t_tx();
		int n;
		slow <= 1'b1;
		bus(1'b1, `RTD_A_TX_PAGE, 32'h0000_0037);
		bus(1'b1, `RTD_A_TX_LEN_LO, 32'h0000_00DE);
		bus(1'b1, `RTD_A_TX_LEN_HI, 32'h0000_0005);
		bus(1'b1, `RTD_A_TX_CTRL, 32'h0000_0001);
		@(posedge hclk);
		chk(tx_dma_addr_q, 16'h3700);
		rdchk(`RTD_A_TX_CTRL, 32'h0000_0002);
		for (n = 0; n < 4000 && tx_last_q !== 1'b1; n++) begin
			@(posedge hclk);
		end
		chk(n < 4000, 1'b1);
		chk(tx_active_q, 1'b0);
		chk(n_taken, 17'd1502);
		chk(tx_dma_addr_q, 16'h3CDE);
	endtask

	// ------------
	// Main sequence
	// ------------
	initial begin
		{hclk, hresetn, hsel, hwrite, htrans, haddr, hwdata, slow, rx_begin, rx_done} = '0;
		{rx_crc_bad, rx_odd_bits, rx_addr_hit, rx_group_addr, rx_no_buffer, rx_fifo_full} = '0;
		{carrier_pin, collision_pin, jabber_pin, t_crc, t_aln, t_mis} = '0;
		hsize = 3'h2;
		failures = 0;
		n_tests = 0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_regs();
		t_rx();
		t_mon();
		t_clear();
		t_defer();
		t_tx();
		finish_test();
	end
endmodule // testbench
